// ---- include/mmpm_pkg.sv ----
// constants and types for the memory mode pin multiplexer
package mmpm_pkg;
    localparam int MMPM_ADDR_W = 14;
    localparam int MMPM_DATA_W = 24;
    localparam int MMPM_IAD_W = 16;
    localparam int MMPM_PF_N = 8;
    localparam int MMPM_MODE_N = 4;
    localparam int MMPM_REG_W = 8;
    localparam int MMPM_RA_W = 3;
    // mode pin positions within the flag pins
    localparam int MMPM_MODE_A = 0;
    localparam int MMPM_MODE_B = 1;
    localparam int MMPM_MODE_C = 2;
    localparam int MMPM_MODE_D = 3;
    // host port functions on the data pins
    localparam int MMPM_D_WR = 7;
    localparam int MMPM_D_RD = 6;
    localparam int MMPM_D_AL = 5;
    localparam int MMPM_D_SEL = 4;
    localparam int MMPM_D_ACK = 3;
    localparam int MMPM_D_IAD_HI = 2;
    localparam int MMPM_D_KEEP_LSB = 8;
    localparam int MMPM_BYTE_PAGE_LSB = 16;
    localparam int MMPM_BYTE_PAGE_W = 8;
    localparam int MMPM_IAD_LO_W = 13;
    // register offsets
    localparam logic [2:0] MMPM_REG_MODE = 3'h0;
    localparam logic [2:0] MMPM_REG_FLAG_DIR = 3'h1;
    localparam logic [2:0] MMPM_REG_FLAG_OUT = 3'h2;
    localparam logic [2:0] MMPM_REG_FLAG_IN = 3'h3;
    localparam logic [2:0] MMPM_REG_IRQ_STATUS = 3'h4;
    localparam logic [2:0] MMPM_REG_IRQ_MASK = 3'h5;
    // reset values
    localparam logic [7:0] MMPM_FLAG_DIR_RST = 8'h00;
    localparam logic [7:0] MMPM_FLAG_OUT_RST = 8'hff;
    localparam logic [7:0] MMPM_IRQ_MASK_RST = 8'h00;
    localparam logic [3:0] MMPM_MODE_RST = 4'h0;
    localparam logic [3:0] MMPM_MODE_ACTIVE_DEF = 4'hf;
    localparam logic [3:0] MMPM_ALWAYS_ACTIVE = 4'hf;
    typedef enum logic [1:0] {
        MMPM_ST_WAIT = 2'b01,
        MMPM_ST_RUN = 2'b10
    } mmpm_state_t;
endpackage

// ---- rtl/mmpm_pin_mux.sv ----
// reset-time mode capture and external pin multiplexer
//
// Operation
// - catch all mode pin levels as reset is released, use them afterwards
// - captured mode chooses self boot from eprom or boot by host
// - host mode bit 0: drive 14-bit address and 24-bit data bus
// - full mode byte access puts upper eight data bits out as address
// - host mode bit 1: 16-bit host port, strobes, ack; keep a0, d23:8
// - host port and controls share address and data pins, mode selects
// - host ack is open drain, its meaning set by captured mode d
// - interrupt flag pins raise events whether driven outside or by us
// - active mode pins work as flags at run time, passive ones do nothing
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mmpm_pin_mux
    import mmpm_pkg::*;
#(
    parameter logic [3:0] MODE_PIN_ACTIVE = MMPM_MODE_ACTIVE_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [MMPM_RA_W-1:0] reg_addr,
    input wire logic [MMPM_REG_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [MMPM_REG_W-1:0] reg_rdata,
    output logic irq,
    // flag pins, low four double as mode pins
    input wire logic [MMPM_PF_N-1:0] pf_in,
    output logic [MMPM_PF_N-1:0] pf_out,
    output logic [MMPM_PF_N-1:0] pf_oe,
    // captured mode
    output logic mode_valid,
    output logic boot_from_host,
    output logic boot_from_eprom,
    output logic host_memory_mode,
    output logic full_memory_mode,
    output logic [MMPM_MODE_N-1:0] mode_value,
    // core bus side
    input wire logic [MMPM_ADDR_W-1:0] core_addr,
    input wire logic [MMPM_DATA_W-1:0] core_data_out,
    input wire logic core_data_oe,
    input wire logic core_byte_access,
    input wire logic [MMPM_BYTE_PAGE_W-1:0] core_byte_page,
    output logic [MMPM_DATA_W-1:0] core_data_in,
    // core host port side
    input wire logic [MMPM_IAD_W-1:0] core_iad_out,
    input wire logic core_iad_oe,
    input wire logic core_host_ready,
    output logic [MMPM_IAD_W-1:0] host_port_addr_data,
    output logic host_write_strobe_n,
    output logic host_read_strobe_n,
    output logic host_addr_latch,
    output logic host_port_select_n,
    // external pins
    input wire logic [MMPM_ADDR_W-1:0] ext_address_bus_in,
    output logic [MMPM_ADDR_W-1:0] ext_address_bus_out,
    output logic [MMPM_ADDR_W-1:0] ext_address_bus_oe,
    input wire logic [MMPM_DATA_W-1:0] ext_data_bus_in,
    output logic [MMPM_DATA_W-1:0] ext_data_bus_out,
    output logic [MMPM_DATA_W-1:0] ext_data_bus_oe
);

    mmpm_state_t state;
    mmpm_state_t next_state;
    logic [MMPM_MODE_N-1:0] mode;
    logic [MMPM_PF_N-1:0] flag_dir;
    logic [MMPM_PF_N-1:0] flag_out;
    logic [MMPM_PF_N-1:0] irq_status;
    logic [MMPM_PF_N-1:0] interrupt_enable_mask;

    wire capture = (state == MMPM_ST_WAIT);
    wire run = (state == MMPM_ST_RUN);

    always_comb begin
        case (state)
            MMPM_ST_WAIT: next_state = MMPM_ST_RUN;
            MMPM_ST_RUN: next_state = MMPM_ST_RUN;
            default: next_state = MMPM_ST_WAIT;
        endcase
    end

    // first clocked edge after release samples the mode pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= MMPM_ST_WAIT;
            mode <= MMPM_MODE_RST;
        end else begin
            state <= next_state;
            if (capture) begin
                mode <= pf_in[MMPM_MODE_N-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_valid <= 1'b0;
            boot_from_host <= 1'b0;
            boot_from_eprom <= 1'b0;
            host_memory_mode <= 1'b0;
            full_memory_mode <= 1'b0;
            mode_value <= MMPM_MODE_RST;
        end else if (capture) begin
            mode_valid <= 1'b1;
            boot_from_host <= pf_in[MMPM_MODE_A];
            boot_from_eprom <= ~pf_in[MMPM_MODE_A];
            host_memory_mode <= pf_in[MMPM_MODE_C];
            full_memory_mode <= ~pf_in[MMPM_MODE_C];
            mode_value <= pf_in[MMPM_MODE_N-1:0];
        end
    end

    wire host_mode = run & mode[MMPM_MODE_C];
    wire full_mode = run & ~mode[MMPM_MODE_C];

    // register decode
    wire wr_dir = reg_write && (reg_addr == MMPM_REG_FLAG_DIR);
    wire wr_out = reg_write && (reg_addr == MMPM_REG_FLAG_OUT);
    wire wr_stat = reg_write && (reg_addr == MMPM_REG_IRQ_STATUS);
    wire wr_mask = reg_write && (reg_addr == MMPM_REG_IRQ_MASK);

    // passive mode pins lose their run-time function
    wire [MMPM_PF_N-1:0] pin_active = {MMPM_ALWAYS_ACTIVE, MODE_PIN_ACTIVE};
    wire [MMPM_PF_N-1:0] pin_level = pf_in & pin_active;
    wire [MMPM_PF_N-1:0] stat_clr = wr_stat ? reg_wdata : {MMPM_PF_N{1'b0}};
    wire [MMPM_PF_N-1:0] pf_event;
    wire [MMPM_PF_N-1:0] next_irq_status;

    genvar gi;
    generate
        for (gi = 0; gi < MMPM_PF_N; gi++) begin : g_pf
            // low pin level requests, whoever drives it
            assign pf_event[gi] = run & pin_active[gi] & ~pf_in[gi];
            // a new event beats the clear
            assign next_irq_status[gi] = pf_event[gi] | (irq_status[gi] & ~stat_clr[gi]);
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_dir <= MMPM_FLAG_DIR_RST;
            flag_out <= MMPM_FLAG_OUT_RST;
            interrupt_enable_mask <= MMPM_IRQ_MASK_RST;
            irq_status <= {MMPM_PF_N{1'b0}};
        end else begin
            if (wr_dir) begin
                flag_dir <= reg_wdata;
            end
            if (wr_out) begin
                flag_out <= reg_wdata;
            end
            if (wr_mask) begin
                interrupt_enable_mask <= reg_wdata;
            end
            irq_status <= next_irq_status;
        end
    end

    wire [MMPM_REG_W-1:0] rd_sel =
        (reg_addr == MMPM_REG_MODE) ? {{(MMPM_REG_W-MMPM_MODE_N){1'b0}}, mode} :
        (reg_addr == MMPM_REG_FLAG_DIR) ? flag_dir :
        (reg_addr == MMPM_REG_FLAG_OUT) ? flag_out :
        (reg_addr == MMPM_REG_FLAG_IN) ? pin_level :
        (reg_addr == MMPM_REG_IRQ_STATUS) ? irq_status :
        (reg_addr == MMPM_REG_IRQ_MASK) ? interrupt_enable_mask :
        {MMPM_REG_W{1'b0}};
    wire [MMPM_REG_W-1:0] next_rdata = reg_read ? rd_sel : {MMPM_REG_W{1'b0}};
    wire next_irq = |(next_irq_status & interrupt_enable_mask);
    wire [MMPM_PF_N-1:0] next_pf_oe = flag_dir & pin_active & {MMPM_PF_N{run}};
    wire [MMPM_PF_N-1:0] next_pf_out = flag_out & pin_active;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= {MMPM_REG_W{1'b0}};
            irq <= 1'b0;
            pf_out <= {MMPM_PF_N{1'b0}};
            pf_oe <= {MMPM_PF_N{1'b0}};
        end else begin
            reg_rdata <= next_rdata;
            irq <= next_irq;
            pf_out <= next_pf_out;
            pf_oe <= next_pf_oe;
        end
    end

    // host port controls as seen on the shared data pins
    wire sel_n_pin = ext_data_bus_in[MMPM_D_SEL];
    wire host_sel = host_mode & ~sel_n_pin;
    wire iad_drive = host_sel & core_iad_oe;
    // mode d turns ack from ready into busy
    wire ack_assert = mode[MMPM_MODE_D] ? ~core_host_ready : core_host_ready;
    wire ack_drive = host_sel & ack_assert;

    // full memory pin values
    // byte page goes out on reads as well, so the upper bits drive then too
    wire byte_page_on = core_byte_access;
    wire [MMPM_DATA_W-1:0] full_data_out = byte_page_on ?
        {core_byte_page, core_data_out[MMPM_BYTE_PAGE_LSB-1:0]} : core_data_out;
    wire [MMPM_DATA_W-1:0] full_data_oe = {
        {MMPM_BYTE_PAGE_W{core_data_oe | byte_page_on}},
        {MMPM_BYTE_PAGE_LSB{core_data_oe}}};

    // host memory pin values
    wire [MMPM_ADDR_W-1:0] host_addr_out = {core_iad_out[MMPM_IAD_LO_W-1:0], core_addr[0]};
    wire [MMPM_ADDR_W-1:0] host_addr_oe = {{MMPM_IAD_LO_W{iad_drive}}, 1'b1};
    wire [MMPM_DATA_W-1:0] host_data_out = {
        core_data_out[MMPM_DATA_W-1:MMPM_D_KEEP_LSB], 5'h00,
        core_iad_out[MMPM_IAD_W-1:MMPM_IAD_LO_W]};
    wire [MMPM_DATA_W-1:0] host_data_oe = {
        {(MMPM_DATA_W-MMPM_D_KEEP_LSB){core_data_oe}}, 4'h0,
        ack_drive, {(MMPM_D_IAD_HI+1){iad_drive}}};

    // pin selection by captured mode, nothing driven before capture
    wire [MMPM_ADDR_W-1:0] next_addr_out = host_mode ? host_addr_out : core_addr;
    wire [MMPM_ADDR_W-1:0] next_addr_oe = host_mode ? host_addr_oe :
        {MMPM_ADDR_W{full_mode}};
    wire [MMPM_DATA_W-1:0] next_data_out = host_mode ? host_data_out : full_data_out;
    wire [MMPM_DATA_W-1:0] next_data_oe = host_mode ? host_data_oe :
        (full_data_oe & {MMPM_DATA_W{full_mode}});

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_address_bus_out <= {MMPM_ADDR_W{1'b0}};
            ext_address_bus_oe <= {MMPM_ADDR_W{1'b0}};
            ext_data_bus_out <= {MMPM_DATA_W{1'b0}};
            ext_data_bus_oe <= {MMPM_DATA_W{1'b0}};
        end else begin
            ext_address_bus_out <= next_addr_out;
            ext_address_bus_oe <= next_addr_oe;
            ext_data_bus_out <= next_data_out;
            ext_data_bus_oe <= next_data_oe;
        end
    end

    // host port inputs back to the core, idle levels in full mode
    wire [MMPM_IAD_W-1:0] next_iad = host_mode ? {
        ext_data_bus_in[MMPM_D_IAD_HI:0],
        ext_address_bus_in[MMPM_ADDR_W-1:1]} : {MMPM_IAD_W{1'b0}};
    wire next_wr_n = host_mode ? ext_data_bus_in[MMPM_D_WR] : 1'b1;
    wire next_rd_n = host_mode ? ext_data_bus_in[MMPM_D_RD] : 1'b1;
    wire next_al = host_mode & ext_data_bus_in[MMPM_D_AL];
    wire next_sel_n = host_mode ? sel_n_pin : 1'b1;
    wire [MMPM_DATA_W-1:0] next_core_data = host_mode ?
        {ext_data_bus_in[MMPM_DATA_W-1:MMPM_D_KEEP_LSB], 8'h00} : ext_data_bus_in;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_port_addr_data <= {MMPM_IAD_W{1'b0}};
            host_write_strobe_n <= 1'b1;
            host_read_strobe_n <= 1'b1;
            host_addr_latch <= 1'b0;
            host_port_select_n <= 1'b1;
            core_data_in <= {MMPM_DATA_W{1'b0}};
        end else begin
            host_port_addr_data <= next_iad;
            host_write_strobe_n <= next_wr_n;
            host_read_strobe_n <= next_rd_n;
            host_addr_latch <= next_al;
            host_port_select_n <= next_sel_n;
            core_data_in <= next_core_data;
        end
    end

endmodule
`default_nettype wire

// ---- verification/mmpm_pin_mux_sva.sv ----
// port assertions for the mode capture and pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module mmpm_pin_mux_sva
    import mmpm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [MMPM_PF_N-1:0] pf_in,
    input wire logic mode_valid,
    input wire logic boot_from_host,
    input wire logic boot_from_eprom,
    input wire logic host_memory_mode,
    input wire logic full_memory_mode,
    input wire logic [MMPM_MODE_N-1:0] mode_value,
    input wire logic [MMPM_ADDR_W-1:0] core_addr,
    input wire logic core_byte_access,
    input wire logic [MMPM_BYTE_PAGE_W-1:0] core_byte_page,
    input wire logic host_port_select_n,
    input wire logic [MMPM_ADDR_W-1:0] ext_address_bus_out,
    input wire logic [MMPM_ADDR_W-1:0] ext_address_bus_oe,
    input wire logic [MMPM_DATA_W-1:0] ext_data_bus_in,
    input wire logic [MMPM_DATA_W-1:0] ext_data_bus_out,
    input wire logic [MMPM_DATA_W-1:0] ext_data_bus_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_mode_capture: assert property ($rose(mode_valid) |-> mode_value == $past(pf_in[3:0]))
        else $error("mode pins not captured at release");
    a_boot_pick: assert property (mode_valid |-> boot_from_host == mode_value[MMPM_MODE_A]
        && boot_from_eprom == !boot_from_host) else $error("boot source wrong");
    a_mem_pick: assert property (mode_valid |-> host_memory_mode == mode_value[MMPM_MODE_C]
        && full_memory_mode == !host_memory_mode) else $error("memory mode wrong");
    a_addr_drive: assert property (full_memory_mode && $past(mode_valid) |->
        &ext_address_bus_oe && ext_address_bus_out == $past(core_addr))
        else $error("address bus not driven from core");
    a_byte_page: assert property (full_memory_mode && $past(mode_valid) && $past(core_byte_access)
        |-> &ext_data_bus_oe[23:16] && ext_data_bus_out[23:16] == $past(core_byte_page))
        else $error("byte page missing");
    a_ctl_inputs: assert property (host_memory_mode && $past(mode_valid) |-> ext_data_bus_oe[7:4] == 4'h0)
        else $error("host control pins driven");
    a_host_select: assert property (host_memory_mode && $past(mode_valid) |->
        host_port_select_n == $past(ext_data_bus_in[MMPM_D_SEL])) else $error("select not passed");
    a_ack_drain: assert property (host_memory_mode && ext_data_bus_oe[MMPM_D_ACK] |->
        !ext_data_bus_out[MMPM_D_ACK]) else $error("ack driven high");
    a_mode_hold: assert property ($past(mode_valid) |-> $stable(mode_value))
        else $error("captured mode changed");
    c_capture: cover property ($rose(mode_valid));
    c_byte: cover property (full_memory_mode && core_byte_access);
    c_host_sel: cover property (host_memory_mode && !host_port_select_n);
endmodule
bind mmpm_pin_mux mmpm_pin_mux_sva u_sva (.clk(clk), .rst_n(rst_n), .pf_in(pf_in),
    .mode_valid(mode_valid), .boot_from_host(boot_from_host), .boot_from_eprom(boot_from_eprom),
    .host_memory_mode(host_memory_mode), .full_memory_mode(full_memory_mode),
    .mode_value(mode_value), .core_addr(core_addr), .core_byte_access(core_byte_access),
    .core_byte_page(core_byte_page), .host_port_select_n(host_port_select_n),
    .ext_address_bus_out(ext_address_bus_out), .ext_address_bus_oe(ext_address_bus_oe),
    .ext_data_bus_in(ext_data_bus_in), .ext_data_bus_out(ext_data_bus_out),
    .ext_data_bus_oe(ext_data_bus_oe));
`default_nettype wire

// ---- verification/mmpm_host_model.sv ----
// board straps, flag drivers and host processor around the pins
`timescale 1ns/1ps
`default_nettype none
module mmpm_host_model (
    input wire logic rst_n,
    input wire logic [3:0] strap,
    input wire logic [7:0] flag_drv,
    input wire logic [15:0] host_iad,
    input wire logic [3:0] host_ctl,
    input wire logic [7:0] pf_out,
    input wire logic [7:0] pf_oe,
    output logic [7:0] pf_in,
    input wire logic [13:0] ext_address_bus_out,
    input wire logic [13:0] ext_address_bus_oe,
    output logic [13:0] ext_address_bus_in,
    input wire logic [23:0] ext_data_bus_out,
    input wire logic [23:0] ext_data_bus_oe,
    output logic [23:0] ext_data_bus_in
);
    // host only fitted when strapped for host mode; idle lines and ack pulled up
    wire logic host_on = strap[2];
    wire logic [7:0] pf_ext = rst_n ? flag_drv : {flag_drv[7:4], strap};
    wire logic [13:0] a_ext = host_on ? {host_iad[12:0], 1'h1} : 14'h3fff;
    wire logic [23:0] d_ext = host_on ? {16'hffff, host_ctl, 1'h1, host_iad[15:13]} : 24'hffffff;
    assign pf_in = (pf_oe & pf_out) | (~pf_oe & pf_ext);
    assign ext_address_bus_in = (ext_address_bus_oe & ext_address_bus_out)
        | (~ext_address_bus_oe & a_ext);
    assign ext_data_bus_in = (ext_data_bus_oe & ext_data_bus_out) | (~ext_data_bus_oe & d_ext);
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the mode capture and pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mmpm_pkg::*;
    typedef struct {int sel; logic [23:0] v; int due;} mmpm_note_t;
    mmpm_note_t q[$];
    mmpm_note_t n;
    logic clk = 1'h0, rst_n = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
    logic core_byte_access = 1'h0, core_host_ready = 1'h0, irq, mode_valid, boot_from_host;
    logic core_data_oe = 1'h1, strap_rel_n = 1'h0;
    logic boot_from_eprom, host_memory_mode, full_memory_mode, host_addr_latch;
    logic host_write_strobe_n, host_read_strobe_n, host_port_select_n;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h0, core_byte_page = 8'h0, flag_drv = 8'hff;
    logic [7:0] reg_rdata, pf_in, pf_out, pf_oe;
    logic [13:0] core_addr = 14'h0, ext_address_bus_in, ext_address_bus_out, ext_address_bus_oe;
    logic [23:0] ext_data_bus_in, ext_data_bus_out, ext_data_bus_oe;
    logic [15:0] host_port_addr_data, host_iad = 16'h0;
    logic [3:0] mode_value, strap = 4'h0, host_ctl = 4'hd;
    int seed = 32'h3dfc, cyc = 0, mismatches = 0, n_tests = 0;
    mmpm_pin_mux #(.MODE_PIN_ACTIVE(4'h7)) u_dut (.clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .irq, .pf_in, .pf_out, .pf_oe, .mode_valid,
        .boot_from_host, .boot_from_eprom, .host_memory_mode, .full_memory_mode, .mode_value,
        .core_addr, .core_data_out(24'h0), .core_data_oe, .core_byte_access,
        .core_byte_page, .core_data_in(), .core_iad_out(16'h0), .core_iad_oe(1'h0),
        .core_host_ready, .host_port_addr_data, .host_write_strobe_n, .host_read_strobe_n,
        .host_addr_latch, .host_port_select_n, .ext_address_bus_in, .ext_address_bus_out,
        .ext_address_bus_oe, .ext_data_bus_in, .ext_data_bus_out, .ext_data_bus_oe);
    mmpm_host_model u_host (.rst_n(strap_rel_n), .strap, .flag_drv, .host_iad, .host_ctl,
        .pf_out, .pf_oe,
        .pf_in, .ext_address_bus_out, .ext_address_bus_oe, .ext_address_bus_in,
        .ext_data_bus_out, .ext_data_bus_oe, .ext_data_bus_in);
    function automatic logic [23:0] obs(input int s);
        case (s)
            0: return {16'h0, reg_rdata};
            1: return {10'h0, ext_address_bus_out};
            2: return {16'h0, ext_data_bus_out[23:16]};
            3: return {18'h0, boot_from_host, full_memory_mode, mode_value};
            4: return {23'h0, irq};
            5: return {4'h0, host_write_strobe_n, host_read_strobe_n, host_addr_latch,
                host_port_select_n, host_port_addr_data};
            default: return {23'h0, ext_data_bus_in[MMPM_D_ACK]};
        endcase
    endfunction
    task automatic look(input int s, input logic [23:0] v);
        q.push_back('{s, v, cyc + 1});
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clk);
        reg_write <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clk);
        reg_read <= 1'h0;
        look(0, {16'h0, d});
        @(posedge clk);
    endtask
    task automatic boot(input logic [3:0] s);
        rst_n <= 1'h0;
        strap <= s;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
    endtask
    task automatic close_out();
        if (q.size() != 0)
            mismatches++;
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        forever #20 clk = ~clk;
    end
    // straps stay on the mode pins until the first edge after release
    always @(posedge clk or negedge rst_n) begin
        strap_rel_n <= rst_n;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            close_out();
        end
    end
    always @(negedge clk) begin
        while (q.size() > 0 && q[0].due == cyc) begin
            n = q.pop_front();
            n_tests++;
            if (obs(n.sel) !== n.v) begin
                mismatches++;
                $display("[FAIL] obs%0d expected %h seen %h", n.sel, n.v, obs(n.sel));
            end
        end
    end
    initial begin
        boot(4'h9);
        look(3, 24'h39);
        wr(MMPM_REG_MODE, 8'h00);
        rd(MMPM_REG_MODE, 8'h09);
        core_byte_access <= 1'h1;
        repeat (4) begin
            core_addr <= 14'($random(seed));
            core_byte_page <= 8'($random(seed));
            core_data_oe <= 1'($random(seed));
            @(posedge clk);
            look(1, {10'h0, core_addr});
            look(2, {16'h0, core_byte_page});
        end
        wr(MMPM_REG_IRQ_MASK, 8'h20);
        flag_drv <= 8'h96;
        @(posedge clk);
        flag_drv <= 8'hff;
        @(posedge clk);
        look(4, 24'h1);
        look(3, 24'h39);
        rd(MMPM_REG_IRQ_STATUS, 8'h61);
        wr(MMPM_REG_IRQ_STATUS, 8'h20);
        look(4, 24'h0);
        rd(MMPM_REG_IRQ_STATUS, 8'h41);
        wr(MMPM_REG_FLAG_DIR, 8'h10);
        wr(MMPM_REG_FLAG_OUT, 8'hef);
        wr(MMPM_REG_FLAG_DIR, 8'h00);
        rd(MMPM_REG_IRQ_STATUS, 8'h51);
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00);
        rd(MMPM_REG_FLAG_OUT, 8'hef);
        boot(4'h4);
        look(3, 24'h04);
        host_iad <= 16'($random(seed));
        host_ctl <= 4'h6;
        core_host_ready <= 1'h1;
        @(posedge clk);
        look(5, {8'h6, host_iad});
        @(posedge clk);
        look(6, 24'h0);
        core_host_ready <= 1'h0;
        repeat (2) @(posedge clk);
        look(6, 24'h1);
        @(posedge clk);
        boot(4'hc);
        look(3, 24'h0c);
        host_ctl <= 4'hc;
        repeat (2) @(posedge clk);
        look(6, 24'h0);
        look(1, {23'h0, core_addr[0]});
        core_host_ready <= 1'h1;
        repeat (2) @(posedge clk);
        look(6, 24'h1);
        @(posedge clk);
        close_out();
    end
endmodule
`default_nettype wire
